// ===== ops_beeper.sv
// Buzzer pulse stretcher
`default_nettype none
module ops_beeper
  import ops_pkg::*;
#(
  parameter int unsigned BEEP_CYCLES = 5000000
)
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic beep_req,
  output var  logic buzzer
);
  ops_beep_e   state_q;
  logic [31:0] cnt_q;

  // A new request restarts the tone so rapid presses stay audible
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= OPS_BEEP_IDLE;
      cnt_q   <= 32'h0;
      buzzer  <= 1'b0;
    end
    else if (beep_req)
    begin
      state_q <= OPS_BEEP_ON;
      cnt_q   <= BEEP_CYCLES - 32'h1;
      buzzer  <= 1'b1;
    end
    else
    begin
      unique case (state_q)
        OPS_BEEP_IDLE:
        begin
          buzzer <= 1'b0;
        end
        OPS_BEEP_ON:
        begin
          if (cnt_q == 32'h0)
          begin
            state_q <= OPS_BEEP_IDLE;
            buzzer  <= 1'b0;
          end
          else
          begin
            cnt_q <= cnt_q - 32'h1;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== ops_cfg.svh
// Constants for the operator panel settings block
// Function
// RULE1 - Run key starts forward when direction setting is 0, reverse when 1; resets 0.
// RULE2 - Language code holds 0 to 7, one language each, 1 after reset.
// RULE3 - Dial mode 0 is frequency setting, 1 potentiometer, key lock off; resets 0.
// RULE4 - Operator presses mode key to confirm dial mode or key lock setting.
// RULE5 - Under key lock, held disabled key shows lock indication and is ignored.
// RULE6 - Stop/reset key keeps working while key lock is active.
// RULE7 - Step setting 0 means each dial click changes frequency by 0.01Hz.
// RULE8 - Step values 0.01, 0.1, 1, 10 change frequency exactly that per click.
// RULE9 - At set frequency 100 or above, dial step is at least 0.1.
// RULE10 - At machine speed 1000 or above, dial step is at least 1.
// RULE11 - Selected step applies only while editing set frequency, not other parameters.
// RULE12 - With machine speed display, minimum increment also comes from step setting.
// RULE13 - Buzzer beeps on each key press when setting is 1, silent at 0; resets 1.
// RULE14 - With buzzer enabled, a fault also sounds an alert beep.
// RULE15 - Contrast 0 lightest to 63 darkest, reset 58, lower is lighter.
// RULE16 - Contrast is stored only when the operator presses the write key.
// RULE17 - Panel settings are writable only while extended visibility setting is 0.
// RULE18 - Step, buzzer and contrast writable during operation even with write protect 0.
// RULE19 - Contrast is listed as simple parameter only while parameter unit connected; the code only reports pu_connected as status bit 6.
// RULE20 - Clockwise click adds one step, counter-clockwise subtracts one step.
`ifndef OPS_CFG_SVH
`define OPS_CFG_SVH
`define OPS_OFS_RUNDIR   8'h00
`define OPS_OFS_LANG     8'h04
`define OPS_OFS_DMODE    8'h08
`define OPS_OFS_STEP     8'h0c
`define OPS_OFS_BUZZ     8'h10
`define OPS_OFS_CONTR    8'h14
`define OPS_OFS_PROT     8'h18
`define OPS_OFS_FREQ     8'h1c
`define OPS_OFS_STATUS   8'h20
`define OPS_RST_LANG     3'h1
`define OPS_RST_BUZZ     1'h1
`define OPS_RST_CONTR    6'h3a
`define OPS_STEP_MAXCODE 3'h4
`define OPS_FREQ_100HZ   24'h002710
`define OPS_SPEED_1000   24'h0186a0
`define OPS_CNT_001      24'h000001
`define OPS_CNT_01       24'h00000a
`define OPS_CNT_1        24'h000064
`define OPS_CNT_10       24'h0003e8
`define OPS_CLK_MHZ      100
`define OPS_BEEP_US      50000
`endif

// ===== ops_key_scan.sv
// Key press edge detection
`default_nettype none
module ops_key_scan
  import ops_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic key_run,
  input  wire logic key_stop,
  input  wire logic key_mode,
  input  wire logic key_write,
  input  wire logic key_other,
  ops_keys_if.src   keys
);
  logic [4:0] prev_q;
  logic [4:0] now_w;
  assign now_w = {key_other, key_write, key_mode, key_stop, key_run};

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prev_q          <= 5'h00;
      keys.run_p      <= 1'b0;
      keys.stop_p     <= 1'b0;
      keys.mode_p     <= 1'b0;
      keys.write_p    <= 1'b0;
      keys.other_p    <= 1'b0;
      keys.any_p      <= 1'b0;
      keys.held_run   <= 1'b0;
      keys.held_write <= 1'b0;
      keys.held_other <= 1'b0;
    end
    else
    begin
      prev_q          <= now_w;
      keys.run_p      <= now_w[0] & ~prev_q[0];
      keys.stop_p     <= now_w[1] & ~prev_q[1];
      keys.mode_p     <= now_w[2] & ~prev_q[2];
      keys.write_p    <= now_w[3] & ~prev_q[3];
      keys.other_p    <= now_w[4] & ~prev_q[4];
      keys.any_p      <= |(now_w & ~prev_q);
      keys.held_run   <= now_w[0];
      keys.held_write <= now_w[3];
      keys.held_other <= now_w[4];
    end
  end
endmodule
`default_nettype wire

// ===== ops_keys_if.sv
// Key event carrier between key scanner and settings core
`default_nettype none
interface ops_keys_if;
  logic run_p;
  logic stop_p;
  logic mode_p;
  logic write_p;
  logic other_p;
  logic any_p;
  logic held_run;
  logic held_write;
  logic held_other;
  modport src (output run_p, stop_p, mode_p, write_p, other_p, any_p, held_run, held_write, held_other);
  modport dst (input run_p, stop_p, mode_p, write_p, other_p, any_p, held_run, held_write, held_other);
endinterface
`default_nettype wire

// ===== ops_operator_model.sv
// Behavioural operator working the panel keys and the setting dial
`default_nettype none
module ops_operator_model
(
  input  wire logic       clk,
  output var  logic [4:0] keys,
  output var  logic       dial_cw,
  output var  logic       dial_ccw
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    keys     = 5'h00;
    dial_cw  = 1'b0;
    dial_ccw = 1'b0;
  end
  // Keys 0 run, 1 stop, 2 mode, 3 write, 4 other
  // Key presses; low gap so the next press counts
  task press(input int idx, input int hold);
    @(posedge clk);
    keys[idx] <= 1'b1;
    repeat (hold) @(posedge clk);
    keys[idx] <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // One click pulse, never both directions at once
  task click(input logic cw);
    @(posedge clk);
    dial_cw  <= cw;
    dial_ccw <= ~cw;
    @(posedge clk);
    dial_cw  <= 1'b0;
    dial_ccw <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== ops_panel_top.sv
// Operator panel settings core with Wishbone register slave
`include "ops_cfg.svh"
`default_nettype none
module ops_panel_top
  import ops_pkg::*;
#(
  parameter int unsigned BEEP_CYCLES = `OPS_BEEP_US * `OPS_CLK_MHZ,
  parameter int unsigned FREQ_W      = 24
)
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  input  wire logic [3:0]        wb_sel_i,
  output var  logic [31:0]       wb_dat_o,
  output var  logic              wb_ack_o,
  input  wire logic              key_run,
  input  wire logic              key_stop,
  input  wire logic              key_mode,
  input  wire logic              key_write,
  input  wire logic              key_other,
  input  wire logic              dial_cw,
  input  wire logic              dial_ccw,
  input  wire logic              edit_set_freq,
  input  wire logic              fault,
  input  wire logic              pu_connected,
  output var  logic              motor_run,
  output var  logic              motor_reverse,
  output var  logic              hold_ind,
  output logic                   buzzer,
  output var  logic [5:0]        lcd_contrast,
  output var  logic [2:0]        display_lang,
  output var  logic              pot_mode,
  output var  logic              key_lock,
  output var  logic [FREQ_W-1:0] set_freq
);
  ops_keys_if keys ();

  ops_key_scan u_scan (
    .clk       (clk),
    .reset_n   (reset_n),
    .key_run   (key_run),
    .key_stop  (key_stop),
    .key_mode  (key_mode),
    .key_write (key_write),
    .key_other (key_other),
    .keys      (keys.src)
  );

  logic       rundir_q;
  logic [2:0] lang_q;
  logic [1:0] dmode_pend_q;
  logic [1:0] dmode_q;
  ops_step_e  step_q;
  logic       buzz_q;
  logic [5:0] contr_pend_q;
  logic       ext_vis_q;
  ops_wprot_e wprot_q;
  logic       speed_sel_q;
  logic       fault_q;
  logic       beep_req_q;

  ops_beeper #(.BEEP_CYCLES(BEEP_CYCLES)) u_beep (
    .clk      (clk),
    .reset_n  (reset_n),
    .beep_req (beep_req_q),
    .buzzer   (buzzer)
  );

  // Byte-lane merge of a write onto the current value
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    return r;
  endfunction

  // Dial increment in 0.01 units
  function automatic logic [FREQ_W-1:0] dial_step(input ops_step_e code, input logic [FREQ_W-1:0] f,
                                                   input logic spd, input logic edit);
    logic [23:0] s;
    s = `OPS_CNT_001;
    if (edit)                                                   // RULE11
    begin
      unique case (code)                                        // RULE8 RULE12
        OPS_STEP_01: s = `OPS_CNT_01;
        OPS_STEP_1:  s = `OPS_CNT_1;
        OPS_STEP_10: s = `OPS_CNT_10;
        default:     s = `OPS_CNT_001;                          // RULE7
      endcase
    end
    if (!spd && f >= FREQ_W'(`OPS_FREQ_100HZ) && s < `OPS_CNT_01) // RULE9
      s = `OPS_CNT_01;
    if (spd && f >= FREQ_W'(`OPS_SPEED_1000) && s < `OPS_CNT_1)   // RULE10
      s = `OPS_CNT_1;
    return FREQ_W'(s);
  endfunction

  // Bus access decode
  logic        acc_w;
  logic        wr_w;
  logic [31:0] cur_w;
  logic [31:0] wv_w;
  logic        grp_a_ok;
  logic        grp_b_ok;
  logic        lock_w;

  assign acc_w  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_w   = acc_w & wb_we_i;
  assign lock_w = dmode_q[1];
  // Direction, language and dial mode wait for a stop under normal protection
  assign grp_a_ok = ~ext_vis_q & (wprot_q == OPS_WP_ANYTIME |
                    (wprot_q == OPS_WP_NORMAL & ~motor_run));   // RULE17
  assign grp_b_ok = ~ext_vis_q & (wprot_q != OPS_WP_LOCKED);    // RULE17 RULE18

  always_comb
  begin
    cur_w = 32'h0;
    unique case (wb_adr_i)
      `OPS_OFS_RUNDIR: cur_w = {31'h0, rundir_q};
      `OPS_OFS_LANG:   cur_w = {29'h0, lang_q};
      `OPS_OFS_DMODE:  cur_w = {28'h0, dmode_q, dmode_pend_q};
      `OPS_OFS_STEP:   cur_w = {29'h0, step_q};
      `OPS_OFS_BUZZ:   cur_w = {31'h0, buzz_q};
      `OPS_OFS_CONTR:  cur_w = {18'h0, lcd_contrast, 2'h0, contr_pend_q};
      `OPS_OFS_PROT:   cur_w = {28'h0, speed_sel_q, wprot_q, ext_vis_q};
      `OPS_OFS_FREQ:   cur_w = {{(32-FREQ_W){1'b0}}, set_freq};
      `OPS_OFS_STATUS: cur_w = {25'h0, pu_connected, fault_q, hold_ind, key_lock, pot_mode,
                                motor_reverse, motor_run};      // RULE19
      default:         cur_w = 32'h0;
    endcase
  end
  assign wv_w = lane_merge(cur_w, wb_dat_i, wb_sel_i);

  // Wishbone handshake, one wait state
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= acc_w;
      wb_dat_o <= acc_w ? cur_w : 32'h0;
    end
  end

  // Settings written by software
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rundir_q     <= 1'b0;                                     // RULE1
      lang_q       <= `OPS_RST_LANG;                            // RULE2
      dmode_pend_q <= 2'h0;                                     // RULE3
      step_q       <= OPS_STEP_OFF;                             // RULE8
      buzz_q       <= `OPS_RST_BUZZ;                            // RULE13
      contr_pend_q <= `OPS_RST_CONTR;                           // RULE15
      ext_vis_q    <= 1'b0;
      wprot_q      <= OPS_WP_NORMAL;
      speed_sel_q  <= 1'b0;
    end
    else if (wr_w)
    begin
      unique case (wb_adr_i)
        `OPS_OFS_RUNDIR: if (grp_a_ok) rundir_q <= wv_w[0];
        `OPS_OFS_LANG:   if (grp_a_ok) lang_q <= wv_w[2:0];     // RULE2
        `OPS_OFS_DMODE:  if (grp_a_ok) dmode_pend_q <= wv_w[1:0];
        `OPS_OFS_STEP:   if (grp_b_ok && wv_w[2:0] <= `OPS_STEP_MAXCODE) step_q <= ops_step_e'(wv_w[2:0]);
        `OPS_OFS_BUZZ:   if (grp_b_ok) buzz_q <= wv_w[0];
        `OPS_OFS_CONTR:  if (grp_b_ok) contr_pend_q <= wv_w[5:0];
        `OPS_OFS_PROT:
        begin
          ext_vis_q   <= wv_w[0];
          wprot_q     <= ops_wprot_e'(wv_w[2:1]);
          speed_sel_q <= wv_w[3];
        end
        default: ;
      endcase
    end
  end

  // Panel mode, lock and contrast taken from operator keys
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dmode_q      <= 2'h0;
      pot_mode     <= 1'b0;
      key_lock     <= 1'b0;
      lcd_contrast <= `OPS_RST_CONTR;
      display_lang <= `OPS_RST_LANG;
    end
    else
    begin
      display_lang <= lang_q;
      if (keys.mode_p)                                          // RULE4
      begin
        dmode_q  <= dmode_pend_q;
        pot_mode <= dmode_pend_q[0];                            // RULE3
        key_lock <= dmode_pend_q[1];
      end
      if (keys.write_p && !lock_w)                              // RULE16
        lcd_contrast <= contr_pend_q;                           // RULE15
    end
  end

  // Run state, hold indication, beeps
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      motor_run     <= 1'b0;
      motor_reverse <= 1'b0;
      hold_ind      <= 1'b0;
      fault_q       <= 1'b0;
      beep_req_q    <= 1'b0;
    end
    else
    begin
      fault_q    <= fault;
      hold_ind   <= lock_w & (keys.held_run | keys.held_write | keys.held_other); // RULE5
      beep_req_q <= buzz_q & (keys.any_p | (fault & ~fault_q)); // RULE13 RULE14
      // Stop is never gated by the lock so the drive can always be halted
      if (keys.stop_p || fault)                                 // RULE6
        motor_run <= 1'b0;
      else if (keys.run_p && !lock_w)                           // RULE5
      begin
        motor_run     <= 1'b1;
        motor_reverse <= rundir_q;                              // RULE1
      end
    end
  end

  // Set frequency; dial clicks saturate rather than wrap
  logic [FREQ_W-1:0] stp_w;
  logic [FREQ_W:0]   up_w;
  assign stp_w = dial_step(step_q, set_freq, speed_sel_q, edit_set_freq);
  assign up_w  = {1'b0, set_freq} + {1'b0, stp_w};

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      set_freq <= '0;
    else if (wr_w && wb_adr_i == `OPS_OFS_FREQ)
      set_freq <= wv_w[FREQ_W-1:0];
    else if (!lock_w && dial_cw && !dial_ccw)                   // RULE20 RULE5
      set_freq <= up_w[FREQ_W] ? '1 : up_w[FREQ_W-1:0];
    else if (!lock_w && dial_ccw && !dial_cw)                   // RULE20
      set_freq <= (set_freq < stp_w) ? '0 : set_freq - stp_w;
  end

  default clocking dc @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_RUN_DIR: assert property (keys.run_p && !lock_w && !keys.stop_p && !fault |=> motor_run && motor_reverse == $past(rundir_q)) // RULE1
    else $error("run key did not start in selected direction");
  AST_LANG_RANGE: assert property (display_lang == $past(lang_q)) // RULE2
    else $error("display language does not follow code");
  AST_MODE_CONFIRM: assert property (!keys.mode_p |=> $stable(dmode_q)) // RULE4
    else $error("dial mode changed without mode key");
  AST_POT_MODE: assert property (keys.mode_p |=> pot_mode == $past(dmode_pend_q[0]) && key_lock == $past(dmode_pend_q[1])) // RULE3
    else $error("confirmed dial mode not applied");
  AST_HOLD: assert property (lock_w && keys.held_other && !keys.mode_p |=> hold_ind) // RULE5
    else $error("lock indication missing while key held");
  AST_LOCK_RUN: assert property (lock_w && !motor_run && !keys.mode_p |=> !motor_run) // RULE5
    else $error("run key acted under lock");
  AST_STOP: assert property (keys.stop_p |=> !motor_run) // RULE6
    else $error("stop key ignored");
  AST_STEP_UP: assert property (!lock_w && dial_cw && !dial_ccw && !wr_w && !up_w[FREQ_W] |=> set_freq == $past(set_freq) + $past(stp_w)) // RULE20
    else $error("dial click did not add one step");
  AST_STEP_MIN: assert property (!speed_sel_q && set_freq >= FREQ_W'(`OPS_FREQ_100HZ) |-> stp_w >= FREQ_W'(`OPS_CNT_01)) // RULE9
    else $error("step below 0.1 at high frequency");
  AST_STEP_NOEDIT: assert property (!edit_set_freq && set_freq < FREQ_W'(`OPS_FREQ_100HZ) |-> stp_w == FREQ_W'(`OPS_CNT_001)) // RULE11
    else $error("step size applied outside set frequency edit");
  AST_BEEP: assert property (keys.any_p && !buzz_q ##1 !buzz_q |-> !beep_req_q) // RULE13
    else $error("beep while buzzer disabled");
  AST_CONTRAST: assert property (!(keys.write_p && !lock_w) |=> $stable(lcd_contrast)) // RULE16
    else $error("contrast stored without write key");
  AST_WB_ACK: assert property (wb_ack_o |=> !wb_ack_o) // Wishbone ack lasts one cycle
    else $error("ack held longer than one cycle");

  COV_RUN_REV: cover property (keys.run_p && rundir_q ##1 motor_run && motor_reverse);
  COV_LOCK_HOLD: cover property (lock_w && keys.held_run ##1 hold_ind);
  COV_STEP_10: cover property (step_q == OPS_STEP_10 && edit_set_freq && dial_cw);
  COV_CONTRAST: cover property (keys.write_p ##1 lcd_contrast != $past(lcd_contrast));
endmodule
`default_nettype wire

// ===== ops_pkg.sv
// Types for the operator panel settings block
`default_nettype none
package ops_pkg;
  typedef enum logic [2:0] {OPS_STEP_OFF, OPS_STEP_001, OPS_STEP_01, OPS_STEP_1, OPS_STEP_10} ops_step_e;
  typedef enum logic [1:0] {OPS_WP_NORMAL, OPS_WP_LOCKED, OPS_WP_ANYTIME, OPS_WP_RSVD} ops_wprot_e;
  typedef enum logic {OPS_BEEP_IDLE, OPS_BEEP_ON} ops_beep_e;
endpackage
`default_nettype wire

// ===== test_ops_panel_top.sv
// Self-checking bench for the operator panel settings block
`include "ops_cfg.svh"
`default_nettype none
module test_ops_panel_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk     = 1'b0;
  logic        reset_n = 1'b0;
  logic        cyc     = 1'b0;
  logic        stb     = 1'b0;
  logic        we      = 1'b0;
  logic [7:0]  adr     = 8'h00;
  logic [31:0] dat     = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [4:0]  keys;
  logic        dial_cw;
  logic        dial_ccw;
  logic        edit    = 1'b1;
  logic        fault   = 1'b0;
  logic        pu_conn = 1'b1;
  logic        buzzer;
  logic [3:0]  sel     = 4'hf;
  logic        o_run;
  logic        o_rev;
  logic        o_hold;
  logic [5:0]  o_contr;
  logic [2:0]  o_lang;
  logic        o_pot;
  logic        o_lock;
  logic [23:0] o_freq;
  int          error_cnt = 0;
  int          checked   = 0;
  logic [31:0] seed      = 32'hf75a0ae9;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [31:0] mon_m;
  logic [31:0] f;
  int          n;
  int unsigned st [5] = '{1, 1, 10, 100, 1000};

  always #5 clk = ~clk;

  ops_operator_model op (.clk(clk), .keys(keys), .dial_cw(dial_cw), .dial_ccw(dial_ccw));

  ops_panel_top #(.BEEP_CYCLES(4)) DUT (
    .clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .key_run(keys[0]), .key_stop(keys[1]), .key_mode(keys[2]), .key_write(keys[3]), .key_other(keys[4]),
    .dial_cw(dial_cw), .dial_ccw(dial_ccw), .edit_set_freq(edit), .fault(fault), .pu_connected(pu_conn),
    .motor_run(o_run), .motor_reverse(o_rev), .hold_ind(o_hold), .buzzer(buzzer), .lcd_contrast(o_contr),
    .display_lang(o_lang), .pot_mode(o_pot), .key_lock(o_lock), .set_freq(o_freq));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    @(posedge clk);
    while (wb_ack_o !== 1'b1) @(posedge clk);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  // Expectation noted first; the monitor compares at the ack edge
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask

  always @(posedge clk)
  begin
    if (wb_ack_o === 1'b1 && we === 1'b0 && exp_q.size() > 0)
    begin
      mon_m = msk_q.pop_front();
      check("wb_dat_o", wb_dat_o & mon_m, exp_q.pop_front() & mon_m);
    end
  end

  // Source 5 raises a fault instead of pressing a key
  task automatic beep(input int src, input logic exp);
    int hi;
    hi = 0;
    fork
      if (src < 5) op.press(src, 1); else fault <= 1'b1;
      repeat (12)
      begin
        @(posedge clk);
        hi += (buzzer === 1'b1);
      end
    join
    fault <= 1'b0;
    check("buzzer", {31'h0, hi != 0}, {31'h0, exp});
  endtask

  task automatic results();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Whole run is a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    results();
  end

  initial
  begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    rd(`OPS_OFS_RUNDIR, 32'h0);
    rd(`OPS_OFS_LANG, 32'h1);
    rd(`OPS_OFS_DMODE, 32'h0);
    rd(`OPS_OFS_STEP, 32'h0);
    rd(`OPS_OFS_BUZZ, 32'h1);
    rd(`OPS_OFS_CONTR, 32'h3a3a);
    rd(8'h24, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      wr(`OPS_OFS_LANG, i);
      rd(`OPS_OFS_LANG, i);
    end
    wr(`OPS_OFS_PROT, 32'h1);
    wr(`OPS_OFS_LANG, 32'h5);
    rd(`OPS_OFS_LANG, 32'h7);
    wr(`OPS_OFS_PROT, 32'h0);
    // Pending contrast only applied by the write key
    wr(`OPS_OFS_CONTR, 32'h5);
    rd(`OPS_OFS_CONTR, 32'h3a05);
    op.press(3, 1);
    rd(`OPS_OFS_CONTR, 32'h0505);
    wr(`OPS_OFS_CONTR, 32'h3f);
    op.press(3, 1);
    rd(`OPS_OFS_CONTR, 32'h3f3f);
    // Unselected low lane keeps the pending contrast
    sel <= 4'he;
    wr(`OPS_OFS_CONTR, 32'h0);
    sel <= 4'hf;
    rd(`OPS_OFS_CONTR, 32'h3f3f);
    wr(`OPS_OFS_RUNDIR, 32'h1);
    op.press(0, 1);
    rd(`OPS_OFS_STATUS, 32'h43, 32'h7f);
    wr(`OPS_OFS_RUNDIR, 32'h0);
    rd(`OPS_OFS_RUNDIR, 32'h1);
    wr(`OPS_OFS_STEP, 32'h3);
    rd(`OPS_OFS_STEP, 32'h3);
    op.press(1, 1);
    rd(`OPS_OFS_STATUS, 32'h40, 32'h7d);
    wr(`OPS_OFS_RUNDIR, 32'h0);
    op.press(0, 1);
    rd(`OPS_OFS_STATUS, 32'h41, 32'h7f);
    // Lock while running, needs the anytime protection mode
    wr(`OPS_OFS_PROT, 32'h4);
    wr(`OPS_OFS_DMODE, 32'h2);
    rd(`OPS_OFS_DMODE, 32'h2);
    op.press(2, 1);
    rd(`OPS_OFS_DMODE, 32'ha);
    fork
      op.press(0, 10);
      begin
        repeat (3) @(posedge clk);
        rd(`OPS_OFS_STATUS, 32'h59, 32'h7d);
      end
    join
    op.press(1, 1);
    rd(`OPS_OFS_STATUS, 32'h48, 32'h7d);
    op.press(0, 1);
    rd(`OPS_OFS_STATUS, 32'h08, 32'h19);
    wr(`OPS_OFS_DMODE, 32'h1);
    op.press(2, 1);
    rd(`OPS_OFS_DMODE, 32'h5);
    rd(`OPS_OFS_STATUS, 32'h04, 32'h0c);
    wr(`OPS_OFS_PROT, 32'h0);
    // Each step code from a random base, random click count
    f = rnd() % 5000;
    wr(`OPS_OFS_FREQ, f);
    for (int c = 0; c < 5; c++)
    begin
      wr(`OPS_OFS_STEP, c);
      n = rnd() % 3 + 1;
      repeat (n) op.click(1'b1);
      f += n * st[c];
      rd(`OPS_OFS_FREQ, f);
      op.click(1'b0);
      f -= st[c];
      rd(`OPS_OFS_FREQ, f);
    end
    wr(`OPS_OFS_STEP, 32'h7);
    rd(`OPS_OFS_STEP, 32'h4);
    wr(`OPS_OFS_FREQ, 32'd10000);
    wr(`OPS_OFS_STEP, 32'h1);
    op.click(1'b1);
    rd(`OPS_OFS_FREQ, 32'd10010);
    wr(`OPS_OFS_PROT, 32'h8);
    wr(`OPS_OFS_FREQ, 32'd100000);
    wr(`OPS_OFS_STEP, 32'h2);
    op.click(1'b1);
    rd(`OPS_OFS_FREQ, 32'd100100);
    wr(`OPS_OFS_PROT, 32'h0);
    edit <= 1'b0;
    wr(`OPS_OFS_FREQ, 32'd20);
    wr(`OPS_OFS_STEP, 32'h4);
    op.click(1'b1);
    rd(`OPS_OFS_FREQ, 32'd21);
    edit <= 1'b1;
    wr(`OPS_OFS_BUZZ, 32'h1);
    beep(4, 1'b1);
    wr(`OPS_OFS_BUZZ, 32'h0);
    beep(4, 1'b0);
    beep(5, 1'b0);
    wr(`OPS_OFS_BUZZ, 32'h1);
    beep(5, 1'b1);
    pu_conn <= 1'b0;
    rd(`OPS_OFS_STATUS, 32'h0, 32'h40);
    pu_conn <= 1'b1;
    rd(`OPS_OFS_STATUS, 32'h40, 32'h40);
    repeat (3) @(posedge clk);
    check("lcd_contrast", {26'h0, o_contr}, 32'h3f);
    check("display_lang", {29'h0, o_lang}, 32'h7);
    check("set_freq", {8'h0, o_freq}, 32'd21);
    check("pot_mode", {31'h0, o_pot}, 32'h1);
    check("key_lock", {31'h0, o_lock}, 32'h0);
    check("motor_run", {31'h0, o_run}, 32'h0);
    check("motor_reverse", {31'h0, o_rev}, 32'h0);
    check("hold_ind", {31'h0, o_hold}, 32'h0);
    results();
  end
endmodule
`default_nettype wire
